// ===== gpwpo_port.sv
// general-purpose port with peripheral, analog, keyboard and oscillator override
//
// Implementation choices: the AHB-Lite register port and the address map.
`include "gpwpo_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - direction 0: input, reads return pin level
// - direction 1: drive output, reads return latch
// - direction bit selects read source under override other than analog
// - enabled peripheral sets direction, direction bit ignored
// - peripheral output pin drives peripheral data
// - analog disables digital, port read gives 0
// - analog wins over digital peripheral
// - keyboard input forces pin to input unless its peripheral is enabled
// - oscillator owns port G bits 5, 6
// - per-pin pullup enable bit turns pullup on
// - pullup off whenever pin is output
// - pullup off under analog control
// - pullup, slew, drive settings act independently
// - data/direction low page, pin control high page
// - reset: inputs, slew on, low drive, no pull
// - reset clears data, zeros not driven
// - data writes latch all bits
module gpwpo_port #(
  parameter int WIDTH = 8,
  parameter bit HAS_OSC = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // shared peripheral control, per pin; oscEn is one bit for the port
  input wire logic [WIDTH-1:0] periphEn,
  input wire logic [WIDTH-1:0] periphOe,
  input wire logic [WIDTH-1:0] periphOut,
  input wire logic [WIDTH-1:0] analogEn,
  input wire logic [WIDTH-1:0] keyInEn,
  input wire logic oscEn,
  // pads
  input wire logic [WIDTH-1:0] padIn,
  output logic [WIDTH-1:0] padOut,
  output logic [WIDTH-1:0] padOe,
  output logic [WIDTH-1:0] pullOn,
  output logic [WIDTH-1:0] slewOn,
  output logic [WIDTH-1:0] driveHigh
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic [WIDTH-1:0] portValueReg;
  logic [WIDTH-1:0] portValueNext;
  logic [WIDTH-1:0] dirReg;
  logic [WIDTH-1:0] dirNext;
  logic [WIDTH-1:0] pullReg;
  logic [WIDTH-1:0] pullNext;
  logic [WIDTH-1:0] slewReg;
  logic [WIDTH-1:0] slewNext;
  logic [WIDTH-1:0] driveReg;
  logic [WIDTH-1:0] driveNext;
  logic [WIDTH-1:0] readBits;
  logic [WIDTH-1:0] osc;
  logic [WIDTH-1:0] oeNext;
  logic [WIDTH-1:0] outNext;
  gpwpo_pkg::gpwpo_sel_t addrSel;
  gpwpo_pkg::gpwpo_sel_t wrSel_reg;
  logic access;
  logic [WIDTH-1:0] rdNext;

  // only trans types NONSEQ/SEQ start a transfer
  assign access = hsel && htrans[1] && hready;

  always_comb begin
    case (haddr[11:0])
      `GPWPO_OFS_DATA: addrSel = gpwpo_pkg::SEL_DATA;
      `GPWPO_OFS_DIR: addrSel = gpwpo_pkg::SEL_DIR;
      `GPWPO_OFS_PULL: addrSel = gpwpo_pkg::SEL_PULL;
      `GPWPO_OFS_SLEW: addrSel = gpwpo_pkg::SEL_SLEW;
      `GPWPO_OFS_DRIVE: addrSel = gpwpo_pkg::SEL_DRIVE;
      default: addrSel = gpwpo_pkg::SEL_NONE;
    endcase
  end

  // write target held from address phase to data phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrSel_reg <= gpwpo_pkg::SEL_NONE;
    end else if (access && hwrite) begin
      wrSel_reg <= addrSel;
    end else begin
      wrSel_reg <= gpwpo_pkg::SEL_NONE;
    end
  end

  // whole-word writes only; unmapped writes fall into SEL_NONE and vanish
  always_comb begin
    portValueNext = portValueReg;
    dirNext = dirReg;
    pullNext = pullReg;
    slewNext = slewReg;
    driveNext = driveReg;
    case (wrSel_reg)
      gpwpo_pkg::SEL_DATA: portValueNext = hwdata[WIDTH-1:0];
      gpwpo_pkg::SEL_DIR: dirNext = hwdata[WIDTH-1:0];
      gpwpo_pkg::SEL_PULL: pullNext = hwdata[WIDTH-1:0];
      gpwpo_pkg::SEL_SLEW: slewNext = hwdata[WIDTH-1:0];
      gpwpo_pkg::SEL_DRIVE: driveNext = hwdata[WIDTH-1:0];
      default: ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      portValueReg <= {WIDTH{`GPWPO_RST_DATA}};
      dirReg <= {WIDTH{`GPWPO_RST_DIR}};
    end else begin
      portValueReg <= portValueNext;
      dirReg <= dirNext;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pullReg <= {WIDTH{`GPWPO_RST_PULL}};
      slewReg <= {WIDTH{`GPWPO_RST_SLEW}};
      driveReg <= {WIDTH{`GPWPO_RST_DRIVE}};
    end else begin
      pullReg <= pullNext;
      slewReg <= slewNext;
      driveReg <= driveNext;
    end
  end

  // read uses next values so a read right behind a write sees the new data
  always_comb begin
    case (addrSel)
      gpwpo_pkg::SEL_DATA: rdNext = readBits;
      gpwpo_pkg::SEL_DIR: rdNext = dirNext;
      gpwpo_pkg::SEL_PULL: rdNext = pullNext;
      gpwpo_pkg::SEL_SLEW: rdNext = slewNext;
      gpwpo_pkg::SEL_DRIVE: rdNext = driveNext;
      default: rdNext = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (access && !hwrite) begin
        hrdata <= 32'(rdNext);
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // each write sequence ends at the data-phase edge, where hwdata stands
  sequence s_write_dir;
    access && hwrite && addrSel == gpwpo_pkg::SEL_DIR ##1 1'b1;
  endsequence

  sequence s_write_pull;
    access && hwrite && addrSel == gpwpo_pkg::SEL_PULL ##1 1'b1;
  endsequence

  sequence s_write_slew;
    access && hwrite && addrSel == gpwpo_pkg::SEL_SLEW ##1 1'b1;
  endsequence

  sequence s_write_drive;
    access && hwrite && addrSel == gpwpo_pkg::SEL_DRIVE ##1 1'b1;
  endsequence

  sequence s_write_none;
    access && hwrite && addrSel == gpwpo_pkg::SEL_NONE ##1 1'b1;
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  read_idle_a: assert property (!(access && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  read_upper_a: assert property ((hrdata >> WIDTH) == 32'h0000_0000)
    else $error("read data above port width not zero");
  dir_latch_a: assert property (
    s_write_dir |-> ##1 dirReg == $past(hwdata[WIDTH-1:0]))
    else $error("direction write not latched");
  pull_latch_a: assert property (
    s_write_pull |-> ##1 pullReg == $past(hwdata[WIDTH-1:0]))
    else $error("pullup write not latched");
  slew_latch_a: assert property (
    s_write_slew |-> ##1 slewReg == $past(hwdata[WIDTH-1:0]))
    else $error("slew write not latched");
  drive_latch_a: assert property (
    s_write_drive |-> ##1 driveReg == $past(hwdata[WIDTH-1:0]))
    else $error("drive write not latched");
  unmapped_write_a: assert property (
    s_write_none |=> $stable(portValueReg) && $stable(dirReg) && $stable(pullReg)
    && $stable(slewReg) && $stable(driveReg))
    else $error("unmapped write changed a register");
  dir_readback_a: assert property (
    (access && !hwrite && addrSel == gpwpo_pkg::SEL_DIR)
    |=> hrdata[WIDTH-1:0] == dirReg)
    else $error("direction read misses a write just before");

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin override logic

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    // analog first, then oscillator, then peripheral, keyboard, port
    assign osc[i] = HAS_OSC && oscEn
      && (i == `GPWPO_OSC_PIN_A || i == `GPWPO_OSC_PIN_B);
    assign oeNext[i] = !analogEn[i] && !osc[i]
      && (periphEn[i] ? periphOe[i] : (!keyInEn[i] && dirNext[i]));
    assign outNext[i] = (periphEn[i] && periphOe[i])
      ? periphOut[i] : portValueNext[i];
    // direction bit picks the read source even under override, analog excepted
    assign readBits[i] = analogEn[i] ? 1'b0
      : (dirNext[i] ? portValueNext[i] : padIn[i]);

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        padOe[i] <= 1'b0;
        padOut[i] <= 1'b0;
        pullOn[i] <= 1'b0;
        slewOn[i] <= 1'b0;
        driveHigh[i] <= 1'b0;
      end else begin
        padOe[i] <= oeNext[i];
        padOut[i] <= (analogEn[i] || osc[i]) ? 1'b0 : outNext[i];
        pullOn[i] <= pullNext[i] && !oeNext[i] && !analogEn[i] && !osc[i];
        // pad controls lose meaning on oscillator pins, so they are masked
        slewOn[i] <= slewNext[i] && !osc[i];
        driveHigh[i] <= driveNext[i] && !osc[i] && !analogEn[i];
      end
    end

    // checks, one set per pin; clock and reset come from the module defaults
    sequence s_read_data;
      access && !hwrite && addrSel == gpwpo_pkg::SEL_DATA;
    endsequence

    sequence s_write_data;
      access && hwrite && addrSel == gpwpo_pkg::SEL_DATA ##1 1'b1;
    endsequence

    property p_in_read;
      s_read_data and (!dirNext[i] && !analogEn[i]) |=> hrdata[i] == $past(padIn[i]);
    endproperty

    in_read_pin_a: assert property (p_in_read)
      else $error("input read does not return pin level");
    out_drive_a: assert property (
      (dirNext[i] && !periphEn[i] && !keyInEn[i] && !analogEn[i] && !osc[i])
      |=> padOe[i] && padOut[i] == portValueReg[i])
      else $error("output pin not driven from data latch");
    ovr_read_a: assert property (
      (s_read_data and (dirNext[i] && periphEn[i] && !analogEn[i]))
      |=> hrdata[i] == portValueReg[i])
      else $error("read under override ignores direction");
    periph_dir_a: assert property (
      (periphEn[i] && !analogEn[i] && !osc[i]) |=> padOe[i] == $past(periphOe[i]))
      else $error("peripheral does not own direction");
    periph_data_a: assert property (
      (periphEn[i] && periphOe[i] && !analogEn[i] && !osc[i])
      |=> padOut[i] == $past(periphOut[i]))
      else $error("peripheral output data not driven");
    analog_mask_a: assert property (
      analogEn[i] |=> !padOe[i] && !pullOn[i] && !driveHigh[i])
      else $error("analog pin keeps digital function");
    analog_read_a: assert property ((s_read_data and analogEn[i]) |=> !hrdata[i])
      else $error("analog pin reads as one");
    key_input_a: assert property ((keyInEn[i] && !periphEn[i]) |=> !padOe[i])
      else $error("keyboard pin not forced to input");
    osc_take_a: assert property (
      osc[i] |=> !padOe[i] && !pullOn[i] && !slewOn[i] && !driveHigh[i])
      else $error("oscillator pin still under port control");
    pull_out_a: assert property (padOe[i] |-> !pullOn[i])
      else $error("pullup on while driving");
    pull_on_a: assert property (
      (pullNext[i] && !oeNext[i] && !analogEn[i] && !osc[i]) |=> pullOn[i])
      else $error("enabled pullup stays off");
    data_latch_a: assert property (
      s_write_data |-> ##1 portValueReg[i] == $past(hwdata[i]))
      else $error("data write not latched");
    reset_state_a: assert property (
      $rose(rst_n) |-> !padOe[i] && !pullOn[i] && slewReg[i] && !driveReg[i]
      && !portValueReg[i])
      else $error("pin not in reset state");
    analog_out_a: assert property (analogEn[i] |=> !padOut[i])
      else $error("analog pin still driven high");
    osc_out_a: assert property (osc[i] |=> !padOut[i])
      else $error("oscillator pin still takes port data");
    slew_follow_a: assert property (!osc[i] |=> slewOn[i] == slewReg[i])
      else $error("slew control does not follow its bit");
    drive_follow_a: assert property (
      (!osc[i] && !analogEn[i]) |=> driveHigh[i] == driveReg[i])
      else $error("drive strength does not follow its bit");
  end

endmodule : gpwpo_port

// ===== gpwpo_regs.svh
// register offsets, reset values and field layout of the port block
`ifndef GPWPO_REGS_SVH
`define GPWPO_REGS_SVH

// low page: data and direction
`define GPWPO_OFS_DATA 12'h000
`define GPWPO_OFS_DIR 12'h004
// high page: pin control
`define GPWPO_OFS_PULL 12'h100
`define GPWPO_OFS_SLEW 12'h104
`define GPWPO_OFS_DRIVE 12'h108

// reset values, one bit per pin, replicated over the port width
`define GPWPO_RST_DATA 1'b0
`define GPWPO_RST_DIR 1'b0
`define GPWPO_RST_PULL 1'b0
`define GPWPO_RST_SLEW 1'b1
`define GPWPO_RST_DRIVE 1'b0

// oscillator pin positions
`define GPWPO_OSC_PIN_A 5
`define GPWPO_OSC_PIN_B 6

`endif

// ===== gpwpo_pkg.sv
// types shared by the port block
package gpwpo_pkg;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_DATA,
    SEL_DIR,
    SEL_PULL,
    SEL_SLEW,
    SEL_DRIVE
  } gpwpo_sel_t;

  typedef logic [1:0] gpwpo_trans_t;

endpackage : gpwpo_pkg

// ===== gpwpo_pad_model.sv
// pad model: pin level from port driver, board source and pullup
module gpwpo_pad_model #(
  parameter int WIDTH = 8
) (
  // pad controls
  input wire logic [WIDTH-1:0] padOut,
  input wire logic [WIDTH-1:0] padOe,
  input wire logic [WIDTH-1:0] pullOn,
  // board side
  input wire logic [WIDTH-1:0] extLevel,
  input wire logic [WIDTH-1:0] extOn,
  output logic [WIDTH-1:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // board source beats pullup; a floating pin settles low
  assign padIn = (padOe & padOut) | (~padOe & extOn & extLevel) | (~padOe & ~extOn & pullOn);
endmodule : gpwpo_pad_model

// ===== gpwpo_port_tb.sv
// self-checking bench of the port block
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module gpwpo_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, oscEn = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [7:0] periphEn = 0, periphOe = 0, periphOut = 0, analogEn = 0, keyInEn = 0;
  logic [7:0] padIn, padOut, padOe, pullOn, slewOn, driveHigh;
  logic [7:0] extLevel = 8'h5a, extOn = 8'hff;
  int miscompares = 0, comparisons = 0;
  assign hready = hreadyout;
  gpwpo_port i_gpwpo_port (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .periphEn(periphEn),
    .periphOe(periphOe), .periphOut(periphOut), .analogEn(analogEn), .keyInEn(keyInEn),
    .oscEn(oscEn), .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullOn(pullOn),
    .slewOn(slewOn), .driveHigh(driveHigh));
  gpwpo_pad_model i_gpwpo_pad_model (.padOut(padOut), .padOe(padOe), .pullOn(pullOn),
    .extLevel(extLevel), .extOn(extOn), .padIn(padIn));
  initial begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK("hrdata", e, r)
    `CHK("hresp", 1'b0, hresp)
  endtask : rd
  // pads are registered: let two edges pass, then look between edges
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task pads(input logic [7:0] oe, input logic [7:0] pu);
    settle();
    `CHK("padOe", oe, padOe)
    `CHK("pullOn", pu, pullOn)
  endtask : pads
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    `CHK("hreadyout", 1'b1, hreadyout)
    rst_n <= 1'b1;
    pads(8'h00, 8'h00);
    `CHK("slewOn", 8'hff, slewOn)
    `CHK("driveHigh", 8'h00, driveHigh)
    rd(`GPWPO_OFS_DIR, 32'h0);
    rd(`GPWPO_OFS_SLEW, 32'hff);
    rd(`GPWPO_OFS_DATA, 32'h5a);
    // data first so the new output never shows a stale level
    xfer(1'b1, `GPWPO_OFS_DATA, 32'ha5);
    xfer(1'b1, `GPWPO_OFS_DIR, 32'h0f);
    pads(8'h0f, 8'h00);
    `CHK("padOut", 8'h05, padOut & 8'h0f)
    rd(`GPWPO_OFS_DATA, 32'h55);
    @(posedge clock);
    extOn <= 8'h00;
    xfer(1'b1, `GPWPO_OFS_PULL, 32'hff);
    pads(8'h0f, 8'hf0);
    rd(`GPWPO_OFS_DATA, 32'hf5);
    @(posedge clock);
    periphEn <= 8'h32;
    periphOe <= 8'h10;
    periphOut <= 8'h10;
    pads(8'h1d, 8'he2);
    `CHK("padOut", 8'h10, padOut & 8'h10)
    rd(`GPWPO_OFS_DATA, 32'hf5);
    xfer(1'b1, `GPWPO_OFS_DRIVE, 32'hff);
    @(posedge clock);
    analogEn <= 8'h91;
    pads(8'h0c, 8'h62);
    `CHK("driveHigh", 8'h6e, driveHigh)
    `CHK("padOut", 8'h00, padOut & 8'h91)
    rd(`GPWPO_OFS_DATA, 32'h64);
    @(posedge clock);
    analogEn <= 8'h00;
    periphEn <= 8'h00;
    keyInEn <= 8'h0c;
    pads(8'h03, 8'hfc);
    xfer(1'b1, `GPWPO_OFS_DIR, 32'hff);
    @(posedge clock);
    oscEn <= 1'b1;
    pads(8'h93, 8'h0c);
    `CHK("slewOn", 8'h9f, slewOn)
    `CHK("padOut", 8'h00, padOut & 8'h60)
    rd(`GPWPO_OFS_DATA, 32'ha5);
    xfer(1'b1, 12'h200, 32'h33);
    rd(12'h200, 32'h0);
    rd(`GPWPO_OFS_PULL, 32'hff);
    rd(`GPWPO_OFS_DIR, 32'hff);
    // second reset in mid-run: registers and pads return to their reset state, but oscEn stays on and keeps slewOn bits 5, 6 low
    rst_n <= 1'b0;
    extOn <= 8'hff;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    pads(8'h00, 8'h00);
    `CHK("slewOn", 8'h9f, slewOn)
    rd(`GPWPO_OFS_DIR, 32'h0);
    rd(`GPWPO_OFS_PULL, 32'h0);
    rd(`GPWPO_OFS_DATA, 32'h5a);
    xfer(1'b1, `GPWPO_OFS_DIR, 32'hff);
    pads(8'h93, 8'h00);
    `CHK("padOut", 8'h00, padOut)
    complete_run();
  end
  // the sequence needs about a hundred cycles; this is ample
  initial begin
    #20us;
    miscompares++;
    complete_run();
  end
endmodule : gpwpo_port_tb
